// File: design/dples_pkg.sv
// Constants and types shared by the lane equalization and snoop register bank
package dples_pkg;

	localparam int NUM_LANES    = 4;
	localparam int EQ_SEL_W     = 4;
	localparam int LANE_COUNT_W = 5;

	// Byte sub-addresses on the target port
	localparam logic [7:0] GEN_OFFSET         = 8'h0a;
	localparam logic [7:0] LANE01_EQ_OFFSET   = 8'h10;
	localparam logic [7:0] LANE23_EQ_OFFSET   = 8'h11;
	localparam logic [7:0] SNOOP_STATE_OFFSET = 8'h12;
	localparam logic [7:0] SNOOP_CTRL_OFFSET  = 8'h13;
	localparam logic [7:0] POINTER_RESET      = 8'h00;

	// Values after reset
	localparam logic [7:0] GEN_RESET         = 8'h01;
	localparam logic [7:0] LANE01_EQ_RESET   = 8'h00;
	localparam logic [7:0] LANE23_EQ_RESET   = 8'h00;
	localparam logic [7:0] SNOOP_STATE_RESET = 8'h00;
	localparam logic [7:0] SNOOP_CTRL_RESET  = 8'h00;

	// Field positions
	localparam int GEN_OVERRIDE_BIT = 4;
	localparam int CTL_SEL_LSB      = 0;
	localparam int CTL_SEL_BIT1     = 1;
	localparam int PWR_STATE_LSB    = 5;
	localparam int LANE_COUNT_LSB   = 0;
	localparam int SNOOP_DIS_BIT    = 7;
	localparam int SB_OVR_LSB       = 4;
	localparam int LANE_OFF_LSB     = 0;

	// Control select codes
	localparam logic [1:0] CTL_SHUTDOWN = 2'b00;
	localparam logic [1:0] CTL_IDLE     = 2'b01;
	localparam logic [1:0] CTL_LINK_ON  = 2'b10;

	// Snooped AUX request fields
	localparam logic [3:0]  AUX_NATIVE_WRITE     = 4'h8;
	localparam logic [19:0] DPCD_POWER_ADDR      = 20'h00600;
	localparam logic [19:0] DPCD_LANE_COUNT_ADDR = 20'h00101;
	localparam logic [1:0]  PWR_STATE_ACTIVE     = 2'b01;

	typedef enum logic [2:0] {
		AUX_IDLE,
		AUX_ADDR_MID,
		AUX_ADDR_LOW,
		AUX_LEN,
		AUX_DATA,
		AUX_SKIP
	} dples_aux_state_t;

endpackage

// File: design/dples_aux_snoop.sv
// Passive decoder of AUX request bytes that catches writes to two link locations
module dples_aux_snoop
	import dples_pkg::*;
(
	input  wire logic       core_clk_in,
	input  wire logic       rst_in,
	input  wire logic       aux_valid_in,
	input  wire logic       aux_first_in,
	input  wire logic       aux_end_in,
	input  wire logic [7:0] aux_byte_in,
	output logic            pwr_cap_out,
	output logic            lane_cnt_cap_out,
	output logic [7:0]      cap_data_out
);

	dples_aux_state_t state_q;
	dples_aux_state_t state_d;
	logic [19:0]      addr_q;
	logic             write_q;
	logic             pwr_cap_q;
	logic             lane_cnt_cap_q;
	logic [7:0]       cap_data_q;

	wire logic first_byte = aux_valid_in && aux_first_in;
	wire logic data_byte  = aux_valid_in && !aux_first_in && (state_q == AUX_DATA);
	wire logic hit_pwr    = data_byte && write_q && (addr_q == DPCD_POWER_ADDR);
	wire logic hit_lanes  = data_byte && write_q && (addr_q == DPCD_LANE_COUNT_ADDR);

	always_comb
	begin
		state_d = state_q;
		if (first_byte)
			state_d = AUX_ADDR_MID;
		else if (aux_end_in)
			state_d = AUX_IDLE;
		else if (aux_valid_in)
		begin
			case (state_q)
				AUX_ADDR_MID: state_d = AUX_ADDR_LOW;
				AUX_ADDR_LOW: state_d = AUX_LEN;
				AUX_LEN:      state_d = AUX_DATA;
				AUX_DATA:     state_d = AUX_SKIP;
				default:      state_d = state_q;
			endcase
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			state_q        <= AUX_IDLE;
			addr_q         <= '0;
			write_q        <= 1'b0;
			pwr_cap_q      <= 1'b0;
			lane_cnt_cap_q <= 1'b0;
			cap_data_q     <= 8'h00;
		end
		else
		begin
			state_q        <= state_d;
			pwr_cap_q      <= hit_pwr;
			lane_cnt_cap_q <= hit_lanes;
			if (first_byte)
			begin
				write_q        <= (aux_byte_in[7:4] == AUX_NATIVE_WRITE);
				addr_q[19:16]  <= aux_byte_in[3:0];
			end
			else if (aux_valid_in && state_q == AUX_ADDR_MID)
				addr_q[15:8] <= aux_byte_in;
			else if (aux_valid_in && state_q == AUX_ADDR_LOW)
				addr_q[7:0] <= aux_byte_in;
			if (hit_pwr || hit_lanes)
				cap_data_q <= aux_byte_in;
		end
	end

	assign pwr_cap_out      = pwr_cap_q;
	assign lane_cnt_cap_out = lane_cnt_cap_q;
	assign cap_data_out     = cap_data_q;

endmodule // dples_aux_snoop

// File: design/dples_lane_ctrl.sv
// Lane enable decision from snooped link state or software lane-off bits
module dples_lane_ctrl
	import dples_pkg::*;
(
	input  wire logic                    core_clk_in,
	input  wire logic                    rst_in,
	input  wire logic [1:0]              control_select_in,
	input  wire logic                    snoop_disable_in,
	input  wire logic [NUM_LANES-1:0]    per_lane_off_bits_in,
	input  wire logic [1:0]              pwr_state_in,
	input  wire logic [LANE_COUNT_W-1:0] lane_count_in,
	output logic [NUM_LANES-1:0]         lane_en_out
);

	logic [NUM_LANES-1:0] lane_en_q;
	logic [NUM_LANES-1:0] snoop_en;

	genvar g;
	generate
		for (g = 0; g < NUM_LANES; g++)
		begin : g_lane
			// Lanes below the snooped count carry data, the rest sleep
			assign snoop_en[g] = (pwr_state_in == PWR_STATE_ACTIVE)
				&& (LANE_COUNT_W'(g) < lane_count_in);
		end
	endgenerate

	wire logic link_on = (control_select_in == CTL_LINK_ON);
	wire logic [NUM_LANES-1:0] lane_en_d = !link_on ? '0
		: snoop_disable_in ? ~per_lane_off_bits_in
		: snoop_en;

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			lane_en_q <= '0;
		else
			lane_en_q <= lane_en_d;
	end

	assign lane_en_out = lane_en_q;

endmodule // dples_lane_ctrl

// File: design/dples_regs.sv
// Register bank: lane equalization selectors, snooped link state and lane control
//
// How it works
// - Register 0x10 holds lane 0 selector in bits 3:0, lane 1 in 7:4.
// - Register 0x11 holds lane 2 selector in bits 3:0, lane 3 in 7:4.
// - Override clear: every selector follows the sampled strap pins, reads return it.
// - Override set: software-written selector values drive each lane's equalization.
// - Power-state field 0x12 bits 6:5 captures AUX writes to link address 0x00600.
// - Snooping active: lanes follow the captured power state.
// - Power-state field clears when control select bit 1 falls.
// - Lane-count field 0x12 bits 4:0 captures AUX writes to link address 0x00101.
// - Snooping active: lanes inside the captured count run, others are disabled.
// - Lane-count field clears when control select bit 1 falls.
// - Snooping disabled: lane enables come only from the per-lane off bits.
// - Register 0x13 bit 7 disables snooping; reset value zero keeps it active.
// - Register 0x13 bits 3:0 turn lanes 3..0 off when set.
// - Off bits written while snooping are stored yet leave lanes unchanged.
// - Registers 0x10..0x13 reset to zero; 0x12 bit 7, 0x13 bit 6 read zero.
// - Register 0x0A bit 4 selects strap or register equalization settings.
// - Register 0x0A bits 1:0 control select; only code 10 enables the link.
// - One-byte sub-address pointer; data accesses auto-increment from it.
module dples_regs
	import dples_pkg::*;
#(
	parameter logic [EQ_SEL_W-1:0] EQ_STRAP_0 = 4'h0,
	parameter logic [EQ_SEL_W-1:0] EQ_STRAP_1 = 4'h5,
	parameter logic [EQ_SEL_W-1:0] EQ_STRAP_2 = 4'ha,
	parameter logic [EQ_SEL_W-1:0] EQ_STRAP_3 = 4'hf
)
(
	input  wire logic                          core_clk_in,
	input  wire logic                          rst_in,
	input  wire logic                          reg_wr_in,
	input  wire logic                          reg_wr_first_in,
	input  wire logic [7:0]                    reg_wdata_in,
	input  wire logic                          reg_rd_in,
	output logic [7:0]                         reg_rdata_out,
	output logic                               reg_rvalid_out,
	input  wire logic [1:0]                    eq_strap_pins_in,
	input  wire logic                          aux_valid_in,
	input  wire logic                          aux_first_in,
	input  wire logic                          aux_end_in,
	input  wire logic [7:0]                    aux_byte_in,
	output logic [NUM_LANES*EQ_SEL_W-1:0]      lane_eq_out,
	output logic [NUM_LANES-1:0]               lane_en_out,
	output logic                               eq_register_override_out,
	output logic [1:0]                         control_select_out,
	output logic [1:0]                         sideband_override_out
);

	// Strap decode; the dB steps behind each code live in the analog equalizer
	function automatic logic [EQ_SEL_W-1:0] eq_from_strap(input logic [1:0] strap);
		logic [EQ_SEL_W-1:0] sel;
		sel = EQ_STRAP_0;
		case (strap)
			2'b01:   sel = EQ_STRAP_1;
			2'b10:   sel = EQ_STRAP_2;
			2'b11:   sel = EQ_STRAP_3;
			default: sel = EQ_STRAP_0;
		endcase
		return sel;
	endfunction

	logic [7:0]                    ptr_q;
	logic [7:0]                    rdata_q;
	logic                          rvalid_q;
	logic                          override_q;
	logic [1:0]                    ctl_sel_q;
	logic [1:0]                    strap_q;
	logic [EQ_SEL_W-1:0]           eq_sel_q [NUM_LANES];
	logic [NUM_LANES*EQ_SEL_W-1:0] lane_eq_q;
	logic [1:0]                    pwr_state_q;
	logic [LANE_COUNT_W-1:0]       lane_count_q;
	logic                          snoop_dis_q;
	logic [1:0]                    sb_ovr_q;
	logic [NUM_LANES-1:0]          lane_off_q;
	logic                          pwr_cap;
	logic                          lane_cnt_cap;
	logic [7:0]                    cap_data;

	// Target port decode
	wire logic data_wr  = reg_wr_in && !reg_wr_first_in;
	wire logic wr_gen   = data_wr && (ptr_q == GEN_OFFSET);
	wire logic wr_eq01  = data_wr && (ptr_q == LANE01_EQ_OFFSET);
	wire logic wr_eq23  = data_wr && (ptr_q == LANE23_EQ_OFFSET);
	wire logic wr_ctrl  = data_wr && (ptr_q == SNOOP_CTRL_OFFSET);

	// A falling control select bit 1 wipes the snooped link state
	wire logic ctl1_next = wr_gen ? reg_wdata_in[CTL_SEL_BIT1] : ctl_sel_q[1];
	wire logic ctl1_fall = ctl_sel_q[1] && !ctl1_next;

	wire logic [7:0] eq01_word = {eq_sel_q[1], eq_sel_q[0]};
	wire logic [7:0] eq23_word = {eq_sel_q[3], eq_sel_q[2]};
	wire logic [7:0] gen_word  = {3'b000, override_q, 2'b00, ctl_sel_q};
	wire logic [7:0] state_word = {1'b0, pwr_state_q, lane_count_q};
	wire logic [7:0] ctrl_word  = {snoop_dis_q, 1'b0, sb_ovr_q, lane_off_q};

	// Unmapped sub-addresses read as zero
	logic [7:0] rd_mux;

	always_comb
	begin
		rd_mux = 8'h00;
		if (ptr_q == GEN_OFFSET)
			rd_mux = gen_word;
		else if (ptr_q == LANE01_EQ_OFFSET)
			rd_mux = eq01_word;
		else if (ptr_q == LANE23_EQ_OFFSET)
			rd_mux = eq23_word;
		else if (ptr_q == SNOOP_STATE_OFFSET)
			rd_mux = state_word;
		else if (ptr_q == SNOOP_CTRL_OFFSET)
			rd_mux = ctrl_word;
	end

	// Pointer: a first byte loads it, each data byte or read moves it on
	wire logic       ptr_load = reg_wr_in && reg_wr_first_in;
	wire logic       ptr_step = data_wr || reg_rd_in;
	wire logic [7:0] ptr_d    = ptr_load ? reg_wdata_in
		: ptr_step ? ptr_q + 8'h01
		: ptr_q;
	wire logic [7:0] rdata_d  = reg_rd_in ? rd_mux : rdata_q;

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			ptr_q <= POINTER_RESET;
		else
			ptr_q <= ptr_d;
	end

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			rdata_q <= 8'h00;
		else
			rdata_q <= rdata_d;
	end

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			rvalid_q <= 1'b0;
		else
			rvalid_q <= reg_rd_in;
	end

	wire logic       override_d = wr_gen ? reg_wdata_in[GEN_OVERRIDE_BIT] : override_q;
	wire logic [1:0] ctl_sel_d  = wr_gen ? reg_wdata_in[CTL_SEL_LSB +: 2] : ctl_sel_q;

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			override_q <= GEN_RESET[GEN_OVERRIDE_BIT];
		else
			override_q <= override_d;
	end

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			ctl_sel_q <= GEN_RESET[CTL_SEL_LSB +: 2];
		else
			ctl_sel_q <= ctl_sel_d;
	end

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			strap_q <= 2'b00;
		else
			strap_q <= eq_strap_pins_in;
	end

	genvar g;
	generate
		for (g = 0; g < NUM_LANES; g++)
		begin : g_eq
			localparam int NIB = (g % 2) * EQ_SEL_W;
			wire logic lane_wr = (g < 2) ? wr_eq01 : wr_eq23;
			wire logic [7:0] rst_word = (g < 2) ? LANE01_EQ_RESET : LANE23_EQ_RESET;

			always_ff @(posedge core_clk_in)
			begin
				if (rst_in)
					eq_sel_q[g] <= rst_word[NIB +: EQ_SEL_W];
				else if (!override_q)
					eq_sel_q[g] <= eq_from_strap(strap_q);
				else if (lane_wr)
					eq_sel_q[g] <= reg_wdata_in[NIB +: EQ_SEL_W];
			end

			always_ff @(posedge core_clk_in)
			begin
				if (rst_in)
					lane_eq_q[g*EQ_SEL_W +: EQ_SEL_W] <= '0;
				else
					lane_eq_q[g*EQ_SEL_W +: EQ_SEL_W] <= eq_sel_q[g];
			end
		end
	endgenerate

	dples_aux_snoop u_snoop (
		.core_clk_in      (core_clk_in),
		.rst_in           (rst_in),
		.aux_valid_in     (aux_valid_in),
		.aux_first_in     (aux_first_in),
		.aux_end_in       (aux_end_in),
		.aux_byte_in      (aux_byte_in),
		.pwr_cap_out      (pwr_cap),
		.lane_cnt_cap_out (lane_cnt_cap),
		.cap_data_out     (cap_data)
	);

	// A capture landing on the clearing cycle wins, so no snooped write is lost
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			pwr_state_q  <= SNOOP_STATE_RESET[PWR_STATE_LSB +: 2];
			lane_count_q <= SNOOP_STATE_RESET[LANE_COUNT_LSB +: LANE_COUNT_W];
		end
		else
		begin
			if (pwr_cap)
				pwr_state_q <= cap_data[1:0];
			else if (ctl1_fall)
				pwr_state_q <= 2'b00;
			if (lane_cnt_cap)
				lane_count_q <= cap_data[LANE_COUNT_W-1:0];
			else if (ctl1_fall)
				lane_count_q <= '0;
		end
	end

	// Off bits are always stored; the lane controller decides whether they count
	wire logic                 snoop_dis_d = wr_ctrl ? reg_wdata_in[SNOOP_DIS_BIT] : snoop_dis_q;
	wire logic [1:0]           sb_ovr_d    = wr_ctrl ? reg_wdata_in[SB_OVR_LSB +: 2] : sb_ovr_q;
	wire logic [NUM_LANES-1:0] lane_off_d  =
		wr_ctrl ? reg_wdata_in[LANE_OFF_LSB +: NUM_LANES] : lane_off_q;

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			snoop_dis_q <= SNOOP_CTRL_RESET[SNOOP_DIS_BIT];
		else
			snoop_dis_q <= snoop_dis_d;
	end

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			sb_ovr_q <= SNOOP_CTRL_RESET[SB_OVR_LSB +: 2];
		else
			sb_ovr_q <= sb_ovr_d;
	end

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			lane_off_q <= SNOOP_CTRL_RESET[LANE_OFF_LSB +: NUM_LANES];
		else
			lane_off_q <= lane_off_d;
	end

	dples_lane_ctrl u_lanes (
		.core_clk_in          (core_clk_in),
		.rst_in               (rst_in),
		.control_select_in    (ctl_sel_q),
		.snoop_disable_in     (snoop_dis_q),
		.per_lane_off_bits_in (lane_off_q),
		.pwr_state_in         (pwr_state_q),
		.lane_count_in        (lane_count_q),
		.lane_en_out          (lane_en_out)
	);

	assign reg_rdata_out            = rdata_q;
	assign reg_rvalid_out           = rvalid_q;
	assign lane_eq_out              = lane_eq_q;
	assign eq_register_override_out = override_q;
	assign control_select_out       = ctl_sel_q;
	assign sideband_override_out    = sb_ovr_q;

endmodule // dples_regs

// File: tb/dples_regs_chk.sv
// Concurrent checks on the register bank ports, bound to the top module
module dples_regs_chk
	import dples_pkg::*;
#(
	parameter logic [3:0] EQ_STRAP_0 = 4'h0,
	parameter logic [3:0] EQ_STRAP_1 = 4'h5,
	parameter logic [3:0] EQ_STRAP_2 = 4'ha,
	parameter logic [3:0] EQ_STRAP_3 = 4'hf
)
(
	input wire logic	core_clk_in,
	input wire logic	rst_in,
	input wire logic	reg_wr_in,
	input wire logic	reg_wr_first_in,
	input wire logic [7:0]	reg_wdata_in,
	input wire logic	reg_rd_in,
	input wire logic [7:0]	reg_rdata_out,
	input wire logic	reg_rvalid_out,
	input wire logic [1:0]	eq_strap_pins_in,
	input wire logic [15:0]	lane_eq_out,
	input wire logic [3:0]	lane_en_out,
	input wire logic	eq_register_override_out,
	input wire logic [1:0]	control_select_out,
	input wire logic [1:0]	sideband_override_out
);
	default clocking dcb @(posedge core_clk_in);
	endclocking
	default disable iff (rst_in);

	logic [7:0]	ptr_q, wd_q;
	logic		sd_q;
	logic [3:0]	off_q, strap_eq;
	logic [1:0]	age_q;

	assign strap_eq = eq_strap_pins_in == 2'h0 ? EQ_STRAP_0 : eq_strap_pins_in == 2'h1 ?
		EQ_STRAP_1 : eq_strap_pins_in == 2'h2 ? EQ_STRAP_2 : EQ_STRAP_3;

	// Shadow pointer lets reads be tied to the register they address
	always_ff @(posedge core_clk_in)
	begin
		wd_q <= reg_wdata_in;
		if (rst_in)
		begin
			ptr_q <= POINTER_RESET;
			sd_q <= 1'h0;
			off_q <= 4'h0;
		end
		else if (reg_wr_in && reg_wr_first_in)
			ptr_q <= reg_wdata_in;
		else if (reg_wr_in || reg_rd_in)
		begin
			ptr_q <= ptr_q + 8'h01;
			if (reg_wr_in && ptr_q == SNOOP_CTRL_OFFSET)
			begin
				sd_q <= reg_wdata_in[SNOOP_DIS_BIT];
				off_q <= reg_wdata_in[3:0];
			end
		end
	end

	// Strap pin to lane output is three flops deep, all holding reset values at first
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			age_q <= 2'h0;
		else if (age_q != 2'h3)
			age_q <= age_q + 2'h1;
	end

	sequence s_strap_quiet;
		(age_q == 2'h3 && !eq_register_override_out && $stable(eq_strap_pins_in)) [*3];
	endsequence
	sequence s_sw_quiet;
		(eq_register_override_out && !reg_wr_in) [*3];
	endsequence

	AST_RD_ANSWER: assert property (
		reg_rd_in |=> reg_rvalid_out) else $error("read not answered");
	AST_RD_HOLD: assert property (
		!reg_rd_in |=> !reg_rvalid_out && $stable(reg_rdata_out)) else $error("read data moved");
	AST_GEN_READ: assert property (
		reg_rd_in && ptr_q == GEN_OFFSET |=> reg_rdata_out ==
		{3'h0, $past(eq_register_override_out), 2'h0, $past(control_select_out)})
		else $error("general register read");
	AST_GEN_WRITE: assert property (
		reg_wr_in && !reg_wr_first_in && ptr_q == GEN_OFFSET |=> control_select_out ==
		wd_q[1:0] && eq_register_override_out == wd_q[GEN_OVERRIDE_BIT])
		else $error("general register write");
	AST_CTRL_READ: assert property (
		reg_rd_in && ptr_q == SNOOP_CTRL_OFFSET |=> reg_rdata_out ==
		{$past(sd_q), 1'h0, $past(sideband_override_out), $past(off_q)})
		else $error("lane control read");
	AST_RSVD_STATE: assert property (
		reg_rd_in && ptr_q == SNOOP_STATE_OFFSET |=> !reg_rdata_out[7])
		else $error("reserved state bit set");
	AST_LANES_GATED: assert property (
		control_select_out != CTL_LINK_ON |=> lane_en_out == 4'h0) else $error("lanes on");
	AST_SW_LANES: assert property (
		control_select_out == CTL_LINK_ON && sd_q |=> lane_en_out == ~$past(off_q))
		else $error("lanes differ from off bits");
	AST_EQ_STRAP: assert property (
		s_strap_quiet |-> lane_eq_out == {4{strap_eq}}) else $error("strap selector");
	AST_EQ_HOLD: assert property (
		s_sw_quiet |-> $stable(lane_eq_out)) else $error("programmed selector moved");
endmodule // dples_regs_chk

bind dples_regs dples_regs_chk #(
	.EQ_STRAP_0(EQ_STRAP_0),
	.EQ_STRAP_1(EQ_STRAP_1),
	.EQ_STRAP_2(EQ_STRAP_2),
	.EQ_STRAP_3(EQ_STRAP_3)
) u_chk (
	.core_clk_in(core_clk_in),
	.rst_in(rst_in),
	.reg_wr_in(reg_wr_in),
	.reg_wr_first_in(reg_wr_first_in),
	.reg_wdata_in(reg_wdata_in),
	.reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out),
	.reg_rvalid_out(reg_rvalid_out),
	.eq_strap_pins_in(eq_strap_pins_in),
	.lane_eq_out(lane_eq_out),
	.lane_en_out(lane_en_out),
	.eq_register_override_out(eq_register_override_out),
	.control_select_out(control_select_out),
	.sideband_override_out(sideband_override_out)
);

// File: tb/dples_aux_model.sv
// Behavioural AUX source whose request bytes the snoop watches
module dples_aux_model
(
	input  wire logic		clk_in,
	input  wire logic		go_in,
	input  wire logic		gap_in,
	input  wire logic [3:0]		cmd_in,
	input  wire logic [19:0]	addr_in,
	input  wire logic [7:0]		data_in,
	output logic			valid_out,
	output logic			first_out,
	output logic			end_out,
	output logic [7:0]		byte_out,
	output logic			done_out
);
	timeunit 1ns;
	timeprecision 100ps;

	// Two data bytes so a capture of anything past the first one shows up
	task automatic send();
		logic [7:0] b [6];
		b = '{{cmd_in, addr_in[19:16]}, addr_in[15:8], addr_in[7:0], 8'h01, data_in, 8'hff};
		done_out = 1'h0;
		#1;
		for (int i = 0; i < 6; i++)
		begin
			valid_out = 1'h1;
			first_out = (i == 0);
			byte_out = b[i];
			@(posedge clk_in);
			#1;
			if (gap_in)
			begin
				valid_out = 1'h0;
				first_out = 1'h0;
				byte_out = ~b[i];
				@(posedge clk_in);
				#1;
			end
		end
		valid_out = 1'h0;
		first_out = 1'h0;
		end_out = 1'h1;
		@(posedge clk_in);
		#1;
		end_out = 1'h0;
		done_out = 1'h1;
	endtask

	initial
	begin
		valid_out = 1'h0;
		first_out = 1'h0;
		end_out = 1'h0;
		byte_out = 8'h00;
		done_out = 1'h0;
		forever
		begin
			@(posedge clk_in);
			if (go_in)
				send();
		end
	end
endmodule // dples_aux_model

// File: tb/test_dp_lane_eq_snoop_regs.sv
// Directed bench for the lane equalization and snoop register bank
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin errors++; \
	$display("BAD %s exp %h got %h", nm, ex, got); end end
module test_dp_lane_eq_snoop_regs
	import dples_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [3:0] SQ0 = 4'h1;
	localparam logic [3:0] SQ1 = 4'h6;
	localparam logic [3:0] SQ2 = 4'h9;
	localparam logic [3:0] SQ3 = 4'he;
	logic		clk, rst, wr, wf, rd, rv, ovr, av, af, ae, go, gap, done;
	logic [1:0]	strap, ctl, sb;
	logic [3:0]	en, gc;
	logic [7:0]	wd, rdat, ab, gd;
	logic [15:0]	eq;
	logic [19:0]	ga;
	int		errors, n_checks;

	dples_regs #(.EQ_STRAP_0(SQ0), .EQ_STRAP_1(SQ1), .EQ_STRAP_2(SQ2), .EQ_STRAP_3(SQ3)) u_dut (
		.core_clk_in(clk), .rst_in(rst), .reg_wr_in(wr), .reg_wr_first_in(wf),
		.reg_wdata_in(wd), .reg_rd_in(rd), .reg_rdata_out(rdat), .reg_rvalid_out(rv),
		.eq_strap_pins_in(strap), .aux_valid_in(av), .aux_first_in(af), .aux_end_in(ae),
		.aux_byte_in(ab), .lane_eq_out(eq), .lane_en_out(en), .eq_register_override_out(ovr),
		.control_select_out(ctl), .sideband_override_out(sb));
	dples_aux_model u_aux (.clk_in(clk), .go_in(go), .gap_in(gap), .cmd_in(gc), .addr_in(ga),
		.data_in(gd), .valid_out(av), .first_out(af), .end_out(ae), .byte_out(ab), .done_out(done));

	initial
	begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end

	task automatic p(input logic w, f, r, input logic [7:0] d);
		@(posedge clk);
		#1;
		wr = w;
		wf = f;
		rd = r;
		wd = d;
	endtask
	task automatic idle(input int n);
		repeat (n) p(1'h0, 1'h0, 1'h0, 8'h00);
	endtask
	task automatic wr_reg(input logic [7:0] a, d);
		p(1'h1, 1'h1, 1'h0, a);
		p(1'h1, 1'h0, 1'h0, d);
		idle(2);
	endtask
	task automatic rd_chk(input logic [7:0] ex);
		p(1'h0, 1'h0, 1'h1, 8'h00);
		idle(1);
		`CHK("rvalid", 1'h1, rv)
		`CHK("rdata", ex, rdat)
	endtask
	task automatic rd_at(input logic [7:0] a, ex);
		p(1'h1, 1'h1, 1'h0, a);
		rd_chk(ex);
	endtask
	task automatic aux(input logic [3:0] c, input logic [19:0] a, input logic [7:0] d, input logic g);
		@(posedge clk);
		#1;
		{go, gc, ga, gd, gap} = {1'h1, c, a, d, g};
		@(posedge clk);
		#1;
		go = 1'h0;
		for (int k = 0; k < 30 && done !== 1'h1; k++)
			@(posedge clk);
		if (done !== 1'h1)
		begin
			errors++;
			final_report();
		end
		idle(3);
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic t_reset();
		logic [7:0] ex [10];
		ex = '{GEN_RESET, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, {SQ2, SQ2}, {SQ2, SQ2}, 8'h00, 8'h00};
		`CHK("ctl", CTL_IDLE, ctl)
		`CHK("override", 1'h0, ovr)
		p(1'h1, 1'h1, 1'h0, GEN_OFFSET);
		for (int i = 0; i < 10; i++)
			rd_chk(ex[i]);
	endtask
	task automatic t_eq();
		logic [3:0] m [4];
		m = '{SQ0, SQ1, SQ2, SQ3};
		for (int s = 0; s < 4; s++)
		begin
			strap = 2'(s);
			idle(3);
			`CHK("lane_eq", {4{m[s]}}, eq)
		end
		wr_reg(LANE01_EQ_OFFSET, 8'h34);
		rd_at(LANE01_EQ_OFFSET, {SQ3, SQ3});
		wr_reg(GEN_OFFSET, 8'h12);
		`CHK("override", 1'h1, ovr)
		`CHK("ctl", CTL_LINK_ON, ctl)
		p(1'h1, 1'h1, 1'h0, LANE01_EQ_OFFSET);
		p(1'h1, 1'h0, 1'h0, 8'h21);
		p(1'h1, 1'h0, 1'h0, 8'h43);
		strap = 2'h0;
		idle(3);
		`CHK("lane_eq", 16'h4321, eq)
		rd_at(LANE01_EQ_OFFSET, 8'h21);
		rd_chk(8'h43);
	endtask
	task automatic t_snoop();
		aux(AUX_NATIVE_WRITE, DPCD_LANE_COUNT_ADDR, 8'h02, 1'h0);
		aux(4'h9, DPCD_POWER_ADDR, 8'h01, 1'h0);
		aux(AUX_NATIVE_WRITE, 20'h00602, 8'h01, 1'h1);
		aux(AUX_NATIVE_WRITE, DPCD_POWER_ADDR, 8'h02, 1'h1);
		`CHK("lane_en", 4'h0, en)
		aux(AUX_NATIVE_WRITE, DPCD_POWER_ADDR, 8'h01, 1'h0);
		rd_at(SNOOP_STATE_OFFSET, 8'h22);
		`CHK("lane_en", 4'h3, en)
		wr_reg(SNOOP_CTRL_OFFSET, 8'h01);
		`CHK("lane_en", 4'h3, en)
		p(1'h1, 1'h1, 1'h0, SNOOP_STATE_OFFSET);
		p(1'h1, 1'h0, 1'h0, 8'hff);
		p(1'h1, 1'h0, 1'h0, 8'hf5);
		idle(2);
		`CHK("lane_en", 4'ha, en)
		rd_at(SNOOP_STATE_OFFSET, 8'h22);
		rd_chk(8'hb5);
		`CHK("sideband", 2'h3, sb)
	endtask
	task automatic t_clear();
		logic [1:0] c [4];
		logic [3:0] ex [4];
		c = '{CTL_LINK_ON, CTL_SHUTDOWN, CTL_IDLE, 2'h3};
		ex = '{4'ha, 4'h0, 4'h0, 4'h0};
		for (int i = 0; i < 4; i++)
		begin
			wr_reg(GEN_OFFSET, {6'h04, c[i]});
			`CHK("lane_en", ex[i], en)
			`CHK("ctl", c[i], ctl)
		end
		rd_at(SNOOP_STATE_OFFSET, 8'h00);
	endtask

	initial
	begin
		errors = 0;
		n_checks = 0;
		{rst, wr, wf, rd, wd, strap} = {1'h1, 1'h0, 1'h0, 1'h0, 8'h00, 2'h2};
		{go, gc, ga, gd, gap} = '0;
		repeat (12) @(posedge clk);
		#1;
		rst = 1'h0;
		idle(3);
		t_reset();
		t_eq();
		t_snoop();
		t_clear();
		final_report();
	end
endmodule // test_dp_lane_eq_snoop_regs
